// *** rtl/hofl_fuse_loader.sv ***
// hardware option loader: option store access, boot select, reset gating
`timescale 1ns/10ps
module hofl_fuse_loader #(
  parameter int RST_STRETCH_CYC = hofl_pkg::RST_STRETCH_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // external programmer port
  input wire logic prog_mode,
  input wire logic prog_wr,
  input wire logic prog_erase,
  input wire logic [1:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  input wire logic prog_code_rd,
  input wire logic [7:0] code_rdata,
  output logic [7:0] prog_rdata,
  output logic prog_rvalid,
  // non-volatile option store
  output logic nv_rd,
  output logic [1:0] nv_addr,
  input wire logic [7:0] nv_rdata,
  output logic nv_wr,
  output logic nv_erase,
  output logic [7:0] nv_wdata,
  // reset sources
  input wire logic ext_reset_req,
  input wire logic low_brownout_detector,
  input wire logic high_brownout_detector,
  input wire logic wdog_timeout_flag,
  // cpu start control
  output logic cpu_rst_hold,
  output logic boot_from_loader,
  output logic [15:0] boot_addr,
  // flash map
  output logic loader_present,
  output logic [15:0] loader_start,
  output logic [15:0] prog_region_lo,
  input wire logic prog_limit_wr,
  input wire logic [3:0] prog_limit_wdata,
  output logic [3:0] prog_region_limit,
  // brown-out settings and readout lock
  output logic [1:0] bod_high_level_sel,
  output logic low_brownout_reset_en,
  output logic high_brownout_reset_en,
  output logic readout_lock,
  // watchdog control register
  input wire logic wdog_sw_wr,
  input wire logic [7:0] wdog_sw_wdata,
  output logic [7:0] wdog_control_reg,
  output logic wdog_reset_enable
);

  localparam logic [15:0] STRETCH_LOAD = 16'(RST_STRETCH_CYC);

  hofl_pkg::hofl_state_t state_ff;
  hofl_pkg::hofl_state_t nxt_state;
  logic [7:0] opt_gen_ff;
  logic [7:0] opt_map_ff;
  logic [7:0] opt_wdg_ff;
  logic [1:0] idx_ff;
  logic [15:0] cnt_ff;
  logic cold_ff;
  logic app_ff;
  logic [3:0] limit_ff;
  logic boot_ldr_ff;
  logic [15:0] boot_addr_ff;
  logic [15:0] ldr_start_ff;
  logic [15:0] prog_lo_ff;
  logic [7:0] prog_rdata_ff;
  logic prog_rvalid_ff;
  logic [1:0] nv_addr_ff;
  logic nv_wr_ff;
  logic nv_erase_ff;
  logic [7:0] nv_wdata_ff;
  logic [3:0] ldr_blocks;
  logic [15:0] ldr_start;
  logic pwr_boot;
  logic any_boot;
  logic live;
  logic app_req;
  logic any_req;
  logic wdog_load;

  // option decode; stored active low so an erased byte means off
  assign readout_lock = ~opt_gen_ff[hofl_pkg::GEN_LOCK_BIT];
  assign pwr_boot = ~opt_gen_ff[hofl_pkg::GEN_PWRUP_BOOT_BIT];
  assign any_boot = ~opt_gen_ff[hofl_pkg::GEN_ANYRST_BOOT_BIT];
  assign low_brownout_reset_en = ~opt_gen_ff[hofl_pkg::GEN_LOW_BOR_BIT];
  assign high_brownout_reset_en = ~opt_gen_ff[hofl_pkg::GEN_HIGH_BOR_BIT];
  assign bod_high_level_sel = ~opt_gen_ff[hofl_pkg::GEN_BOD_SEL_LSB +: 2];
  assign ldr_blocks = ~opt_map_ff[hofl_pkg::MAP_LOADER_LSB +: 4];
  assign loader_present = (ldr_blocks != 4'h0);
  // region runs from the start address up to the last flash byte
  assign ldr_start = hofl_pkg::FLASH_END_NEXT - {3'h0, ldr_blocks, 9'h000};

  // sequence status
  assign live = (state_ff == hofl_pkg::ST_STRETCH) || (state_ff == hofl_pkg::ST_RUN);
  // brown-out resets only when their option allows
  assign app_req = (low_brownout_detector && low_brownout_reset_en) ||
                   (high_brownout_detector && high_brownout_reset_en);
  assign wdog_reset_enable = wdog_control_reg[hofl_pkg::WCR_RESET_BIT];
  assign any_req = live && (app_req || ext_reset_req || (wdog_timeout_flag && wdog_reset_enable));
  assign wdog_load = (state_ff == hofl_pkg::ST_CAPT) && (idx_ff == hofl_pkg::OPT_IDX_WDG);

  // outputs straight from flops, except nv_rd and cpu_rst_hold, which are decoded from the state
  assign nv_rd = (state_ff == hofl_pkg::ST_FETCH);
  assign nv_addr = nv_addr_ff;
  assign nv_wr = nv_wr_ff;
  assign nv_erase = nv_erase_ff;
  assign nv_wdata = nv_wdata_ff;
  assign prog_rdata = prog_rdata_ff;
  assign prog_rvalid = prog_rvalid_ff;
  assign boot_from_loader = boot_ldr_ff;
  assign boot_addr = boot_addr_ff;
  assign loader_start = ldr_start_ff;
  assign prog_region_lo = prog_lo_ff;
  assign prog_region_limit = limit_ff;
  assign cpu_rst_hold = (state_ff != hofl_pkg::ST_RUN);

  // next state: load options, stretch the reset, then run
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      hofl_pkg::ST_FETCH: nxt_state = hofl_pkg::ST_CAPT;
      hofl_pkg::ST_CAPT:
      begin
        if (idx_ff == hofl_pkg::OPT_IDX_WDG)
          nxt_state = hofl_pkg::ST_STRETCH;
        else
          nxt_state = hofl_pkg::ST_FETCH;
      end
      hofl_pkg::ST_STRETCH:
      begin
        if ((cnt_ff <= 16'h0001) && !any_req)
          nxt_state = hofl_pkg::ST_RUN;
      end
      hofl_pkg::ST_RUN:
      begin
        if (any_req)
          nxt_state = hofl_pkg::ST_STRETCH;
      end
      default: nxt_state = hofl_pkg::ST_FETCH;
    endcase
  end

  // state register; the cpu stays held until every byte is in
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_ff <= hofl_pkg::ST_FETCH;
    else
      state_ff <= nxt_state;
  end

  // option byte index and store address during the load
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      idx_ff <= hofl_pkg::OPT_IDX_GEN;
      nv_addr_ff <= hofl_pkg::OPT_IDX_GEN;
    end
    else if (state_ff == hofl_pkg::ST_CAPT)
    begin
      idx_ff <= idx_ff + 2'h1;
      nv_addr_ff <= idx_ff + 2'h1;
    end
    else if (live && prog_mode && (prog_wr || prog_erase))
    begin
      nv_addr_ff <= prog_addr;
    end
  end

  // shadow bytes hold the factory image until the store is read
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      opt_gen_ff <= hofl_pkg::FACT_GEN;
      opt_map_ff <= hofl_pkg::FACT_MAP;
      opt_wdg_ff <= hofl_pkg::FACT_WDG;
    end
    else if (state_ff == hofl_pkg::ST_CAPT)
    begin
      case (idx_ff)
        hofl_pkg::OPT_IDX_GEN: opt_gen_ff <= nv_rdata;
        hofl_pkg::OPT_IDX_MAP: opt_map_ff <= nv_rdata;
        hofl_pkg::OPT_IDX_WDG: opt_wdg_ff <= nv_rdata;
        default: opt_gen_ff <= opt_gen_ff;
      endcase
    end
  end

  // programmable region limit: option at power-up, software later
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      limit_ff <= ~hofl_pkg::FACT_MAP[hofl_pkg::MAP_PROG_LSB +: 4];
    else if ((state_ff == hofl_pkg::ST_CAPT) && (idx_ff == hofl_pkg::OPT_IDX_MAP))
      limit_ff <= ~nv_rdata[hofl_pkg::MAP_PROG_LSB +: 4];
    else if (live && prog_limit_wr)
      limit_ff <= prog_limit_wdata;
  end

  // flash map outputs, one cycle behind the options
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ldr_start_ff <= hofl_pkg::FLASH_END_NEXT;
      prog_lo_ff <= hofl_pkg::FLASH_END_NEXT;
    end
    else
    begin
      ldr_start_ff <= ldr_start;
      prog_lo_ff <= ldr_start - {3'h0, limit_ff, 9'h000};
    end
  end

  // stretch counter, restarted by every reset request
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt_ff <= STRETCH_LOAD;
    else if (any_req)
      cnt_ff <= STRETCH_LOAD;
    else if ((state_ff == hofl_pkg::ST_STRETCH) && (cnt_ff != 16'h0000))
      cnt_ff <= cnt_ff - 16'h0001;
  end

  // reset cause: power-up until first run, brown-out marks an application start
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cold_ff <= 1'b1;
      app_ff <= 1'b0;
    end
    else if (any_req)
    begin
      cold_ff <= cold_ff && (state_ff != hofl_pkg::ST_RUN);
      app_ff <= app_ff || app_req;
    end
    else if (nxt_state == hofl_pkg::ST_RUN && state_ff == hofl_pkg::ST_STRETCH)
    begin
      cold_ff <= 1'b0;
      app_ff <= 1'b0;
    end
  end

  // boot source chosen as the cpu is released
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      boot_ldr_ff <= 1'b0;
      boot_addr_ff <= hofl_pkg::APP_START;
    end
    else if (nxt_state == hofl_pkg::ST_RUN && state_ff == hofl_pkg::ST_STRETCH)
    begin
      if (loader_present && !app_ff && (any_boot || (cold_ff && pwr_boot)))
      begin
        boot_ldr_ff <= 1'b1;
        boot_addr_ff <= ldr_start;
      end
      else
      begin
        boot_ldr_ff <= 1'b0;
        boot_addr_ff <= hofl_pkg::APP_START;
      end
    end
  end

  // only the programmer port reaches the option store
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      nv_wr_ff <= 1'b0;
      nv_erase_ff <= 1'b0;
      nv_wdata_ff <= hofl_pkg::OPT_ERASED;
    end
    else
    begin
      nv_wr_ff <= live && prog_mode && prog_wr && !prog_erase;
      nv_erase_ff <= live && prog_mode && prog_erase;
      if (live && prog_mode && prog_wr)
        nv_wdata_ff <= prog_wdata;
    end
  end

  // programmer code read-back, masked while locked
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      prog_rvalid_ff <= 1'b0;
      prog_rdata_ff <= hofl_pkg::LOCKED_BYTE;
    end
    else
    begin
      prog_rvalid_ff <= prog_mode && prog_code_rd;
      if (prog_mode && prog_code_rd)
        prog_rdata_ff <= readout_lock ? hofl_pkg::LOCKED_BYTE : code_rdata;
    end
  end

  // watchdog control register; software writes only once the cpu runs
  hofl_wdog_ctrl u_wdog (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(wdog_load),
    .opt_wdg(wdog_load ? nv_rdata : opt_wdg_ff), // store data is valid only while loading
    .sw_wr(wdog_sw_wr && (state_ff == hofl_pkg::ST_RUN)),
    .sw_wdata(wdog_sw_wdata),
    .wdog_control_reg(wdog_control_reg)
  );

endmodule

// *** rtl/hofl_pkg.sv ***
// shared constants for the hardware option fuse loader
package hofl_pkg;

  // clock rate and release stretch after any reset
  localparam int CLK_MHZ = 125;
  localparam int RST_STRETCH_NS = 200;
  localparam int RST_STRETCH_CYC = (RST_STRETCH_NS * CLK_MHZ + 999) / 1000;

  // option store layout: three bytes, read in index order at power-up
  localparam int OPT_BYTES = 3;
  localparam logic [1:0] OPT_IDX_GEN = 2'h0;
  localparam logic [1:0] OPT_IDX_MAP = 2'h1;
  localparam logic [1:0] OPT_IDX_WDG = 2'h2;

  // general option byte, every bit stored active low so erased reads disabled
  localparam int GEN_LOCK_BIT = 0;
  localparam int GEN_PWRUP_BOOT_BIT = 1;
  localparam int GEN_ANYRST_BOOT_BIT = 2;
  localparam int GEN_LOW_BOR_BIT = 3;
  localparam int GEN_HIGH_BOR_BIT = 4;
  localparam int GEN_BOD_SEL_LSB = 5;

  // map option byte: inverted 512-byte block counts
  localparam int MAP_LOADER_LSB = 0;
  localparam int MAP_PROG_LSB = 4;

  // watchdog option byte, active low
  localparam int WDG_RESET_BIT = 0;
  localparam int WDG_NONSTOP_BIT = 1;
  localparam int WDG_AUTO_BIT = 2;
  localparam int WDG_IDLE_BIT = 3;
  localparam int WDG_PS_LSB = 4;
  localparam int WDG_PROTECT_BIT = 7;

  // erased byte and factory images (1.5K loader, 1K programmable region)
  localparam logic [7:0] OPT_ERASED = 8'hFF;
  localparam logic [7:0] FACT_GEN = 8'hFD;
  localparam logic [7:0] FACT_MAP = 8'hDC;
  localparam logic [7:0] FACT_WDG = 8'hFF;

  // flash map
  localparam logic [15:0] FLASH_LAST = 16'h3FFF;
  localparam logic [15:0] FLASH_END_NEXT = FLASH_LAST + 16'h0001;
  localparam logic [15:0] APP_START = 16'h0000;
  localparam logic [7:0] LOCKED_BYTE = 8'hFF;

  // watchdog control register fields
  localparam int WCR_PS_LSB = 0;
  localparam int WCR_IDLE_BIT = 3;
  localparam int WCR_NONSTOP_BIT = 4;
  localparam int WCR_RESET_BIT = 5;
  localparam int WCR_ENABLE_BIT = 6;
  localparam logic [7:0] WCR_RESET_VAL = 8'h00;

  // loader sequence
  typedef enum logic [1:0] {ST_FETCH, ST_CAPT, ST_STRETCH, ST_RUN} hofl_state_t;

endpackage

// *** rtl/hofl_wdog_ctrl.sv ***
// watchdog control register with option load and write protection
`timescale 1ns/10ps
module hofl_wdog_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // option load at power-up
  input wire logic load,
  input wire logic [7:0] opt_wdg,
  // software access
  input wire logic sw_wr,
  input wire logic [7:0] sw_wdata,
  output logic [7:0] wdog_control_reg
);

  logic [7:0] ctrl_ff;
  logic auto_en;
  logic protect;

  // option bits are stored inverted
  assign auto_en = ~opt_wdg[hofl_pkg::WDG_AUTO_BIT];
  assign protect = ~opt_wdg[hofl_pkg::WDG_PROTECT_BIT];
  assign wdog_control_reg = ctrl_ff;

  // load wins over a software write; the loader holds the cpu anyway
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= hofl_pkg::WCR_RESET_VAL;
    end
    else if (load)
    begin
      ctrl_ff[hofl_pkg::WCR_RESET_BIT] <= ~opt_wdg[hofl_pkg::WDG_RESET_BIT];
      ctrl_ff[hofl_pkg::WCR_NONSTOP_BIT] <= ~opt_wdg[hofl_pkg::WDG_NONSTOP_BIT];
      if (auto_en)
      begin
        ctrl_ff[hofl_pkg::WCR_ENABLE_BIT] <= 1'b1;
        ctrl_ff[hofl_pkg::WCR_IDLE_BIT] <= ~opt_wdg[hofl_pkg::WDG_IDLE_BIT];
        ctrl_ff[hofl_pkg::WCR_PS_LSB +: 3] <= ~opt_wdg[hofl_pkg::WDG_PS_LSB +: 3];
      end
      // with auto enable clear the idle and prescale fields stay untouched
    end
    else if (sw_wr)
    begin
      // the enable bit is never protected
      ctrl_ff[hofl_pkg::WCR_ENABLE_BIT] <= sw_wdata[hofl_pkg::WCR_ENABLE_BIT];
      if (!protect)
      begin
        ctrl_ff[hofl_pkg::WCR_NONSTOP_BIT:hofl_pkg::WCR_PS_LSB] <=
          sw_wdata[hofl_pkg::WCR_NONSTOP_BIT:hofl_pkg::WCR_PS_LSB];
        ctrl_ff[hofl_pkg::WCR_RESET_BIT] <= sw_wdata[hofl_pkg::WCR_RESET_BIT];
      end
    end
  end

endmodule

// *** test/hofl_fuse_loader_chk.sv ***
// port assertions for the option fuse loader
`timescale 1ns/10ps
module hofl_fuse_loader_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // programmer side
  input wire logic prog_mode,
  input wire logic prog_wr,
  input wire logic [7:0] prog_rdata,
  input wire logic prog_rvalid,
  input wire logic nv_wr,
  // reset sources and cpu start
  input wire logic ext_reset_req,
  input wire logic low_brownout_detector,
  input wire logic high_brownout_detector,
  input wire logic wdog_timeout_flag,
  input wire logic cpu_rst_hold,
  input wire logic boot_from_loader,
  input wire logic [15:0] boot_addr,
  // loaded settings
  input wire logic loader_present,
  input wire logic [15:0] loader_start,
  input wire logic [15:0] prog_region_lo,
  input wire logic prog_limit_wr,
  input wire logic [3:0] prog_limit_wdata,
  input wire logic [3:0] prog_region_limit,
  input wire logic low_brownout_reset_en,
  input wire logic high_brownout_reset_en,
  input wire logic readout_lock,
  input wire logic wdog_reset_enable
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // limit lands first, region base follows a cycle later
  sequence s_lim;
    prog_region_limit == $past(prog_limit_wdata) ##1
      prog_region_lo == loader_start - {3'h0, prog_region_limit, 9'h000};
  endsequence
  property p_hold;
    $rose(rst_n) |-> cpu_rst_hold [*8];
  endproperty
  property p_nvwr;
    nv_wr |-> $past(prog_mode && prog_wr);
  endproperty
  property p_lock;
    prog_rvalid && readout_lock |-> prog_rdata == 8'hFF;
  endproperty
  property p_map;
    loader_present && !cpu_rst_hold |->
      loader_start[8:0] == 9'h000 && loader_start inside {[16'h2200:16'h3E00]};
  endproperty
  property p_boot;
    $fell(cpu_rst_hold) |-> (loader_present || !boot_from_loader) &&
      boot_addr == (boot_from_loader ? loader_start : 16'h0000);
  endproperty
  // a new hold needs an enabled cause in the cycle before
  property p_cause;
    $rose(cpu_rst_hold) |-> $past(ext_reset_req ||
      low_brownout_detector && low_brownout_reset_en ||
      high_brownout_detector && high_brownout_reset_en ||
      wdog_timeout_flag && wdog_reset_enable);
  endproperty
  property p_bod;
    !cpu_rst_hold && (low_brownout_detector && low_brownout_reset_en ||
      high_brownout_detector && high_brownout_reset_en) |=> cpu_rst_hold;
  endproperty
  property p_lim;
    prog_limit_wr && !cpu_rst_hold |=> s_lim;
  endproperty
  a_hold: assert property (p_hold)
    else $error("cpu freed during load");
  a_nvwr: assert property (p_nvwr)
    else $error("store write without programmer");
  a_lock: assert property (p_lock)
    else $error("locked read leaked data");
  a_map: assert property (p_map)
    else $error("bad loader start");
  a_boot: assert property (p_boot)
    else $error("bad boot address");
  a_cause: assert property (p_cause)
    else $error("hold without cause");
  a_bod: assert property (p_bod)
    else $error("enabled detector ignored");
  a_lim: assert property (p_lim)
    else $error("limit update wrong");
endmodule

bind hofl_fuse_loader hofl_fuse_loader_chk i_chk (.*);

// *** test/hofl_fuse_loader_tb.sv ***
// self-checking bench for the option fuse loader
`timescale 1ns/10ps
module hofl_fuse_loader_tb;
  logic mclk, rst_n, prog_mode, prog_wr, prog_erase, prog_code_rd, prog_rvalid;
  logic nv_rd, nv_wr, nv_erase, cpu_rst_hold, boot_from_loader, loader_present;
  logic prog_limit_wr, wdog_sw_wr, low_brownout_reset_en, high_brownout_reset_en;
  logic readout_lock, wdog_reset_enable;
  logic [1:0] prog_addr, nv_addr, bod_high_level_sel;
  logic [3:0] src, prog_limit_wdata, prog_region_limit;
  logic [7:0] prog_wdata, code_rdata, prog_rdata, nv_rdata, nv_wdata;
  logic [7:0] wdog_sw_wdata, wdog_control_reg;
  logic [15:0] boot_addr, loader_start, prog_region_lo, e;
  wire ext_reset_req, low_brownout_detector, high_brownout_detector, wdog_timeout_flag;
  int n_errors, samples_checked;
  // reset sources packed as {wdog, high, low, ext}
  assign {wdog_timeout_flag, high_brownout_detector, low_brownout_detector} = src[3:1];
  assign ext_reset_req = src[0];
  // short stretch keeps each power-on brief
  hofl_fuse_loader #(.RST_STRETCH_CYC(2)) i_dut (.*);
  hofl_nv_model i_nv (.*);
  // clock
  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    close_out();
  end
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for cpu release
  task automatic run;
    for (int i = 0; i < 99 && cpu_rst_hold !== 1'h0; i++)
      cyc(1);
    chk(cpu_rst_hold, 1'h0);
  endtask
  task automatic por;
    rst_n = 1'h0;
    cyc(10);
    rst_n = 1'h1;
    cyc(5);
    chk(cpu_rst_hold, 1'h1);
    run();
  endtask
  task automatic boot(input logic [7:0] g, m, w);
    i_nv.mem[0] = g;
    i_nv.mem[1] = m;
    i_nv.mem[2] = w;
    por();
  endtask
  // pulse a reset source; check hold and where the cpu starts
  task automatic rs(input logic [3:0] v, input logic h, b);
    src = v;
    cyc(2);
    chk(cpu_rst_hold, h);
    src = 4'h0;
    run();
    chk(boot_from_loader, b);
  endtask
  task automatic crd(input logic [7:0] d, x);
    prog_mode = 1'h1;
    code_rdata = d;
    prog_code_rd = 1'h1;
    cyc(1);
    prog_code_rd = 1'h0;
    code_rdata = ~d;
    chk({prog_rvalid, prog_rdata}, {1'h1, x});
  endtask
  task automatic pw(input logic [1:0] a, input logic [7:0] d, input logic er);
    prog_mode = 1'h1;
    prog_addr = a;
    prog_wdata = d;
    {prog_wr, prog_erase} = {~er, er};
    cyc(1);
    {prog_wr, prog_erase} = 2'h0;
    chk({nv_wr, nv_erase, nv_wdata}, {~er, er, d});
  endtask
  task automatic wd(input logic [7:0] d, x);
    wdog_sw_wdata = d;
    wdog_sw_wr = 1'h1;
    cyc(1);
    wdog_sw_wr = 1'h0;
    chk(wdog_control_reg, x);
  endtask
  // main sequence
  initial
  begin
    {rst_n, prog_mode, prog_wr, prog_erase, prog_addr, prog_wdata, prog_code_rd} = '0;
    {code_rdata, src, prog_limit_wr, prog_limit_wdata, wdog_sw_wr, wdog_sw_wdata} = '0;
    boot(8'hFF, 8'hFF, 8'hFF);
    chk({loader_present, readout_lock, boot_from_loader}, 16'h0000);
    chk({prog_region_limit, wdog_control_reg}, 16'h0000);
    $display("done erased");
    boot(8'hFD, 8'hDC, 8'hFF);
    chk(boot_addr, 16'h3A00);
    chk(prog_region_lo, 16'h3600);
    crd(8'h5A, 8'h5A);
    prog_limit_wdata = 4'h5;
    prog_limit_wr = 1'h1;
    cyc(1);
    prog_limit_wr = 1'h0;
    chk(prog_region_limit, 4'h5);
    cyc(1);
    chk(prog_region_lo, 16'h3000);
    $display("done factory");
    for (int n = 0; n < 16; n++)
    begin
      boot({1'h1, ~n[1:0], 3'h7, ~n[0], 1'h1}, {4'hD, ~n[3:0]}, 8'hFF);
      e = 16'(32'h4000 - n * 32'h200);
      chk(bod_high_level_sel, n[1:0]);
      chk({loader_present, boot_from_loader}, {n != 0, n[0]});
      if (n != 0)
        chk(boot_addr, n[0] ? e : 16'h0000);
      if (n != 0)
        chk(loader_start, e);
    end
    $display("done sizes");
    boot(8'hFC, 8'hDC, 8'hFF);
    crd(8'h5A, 8'hFF);
    // a write strobe without the programmer attached must not reach the store
    prog_mode = 1'h0;
    prog_wr = 1'h1;
    cyc(1);
    prog_wr = 1'h0;
    chk(nv_wr, 1'h0);
    pw(2'h0, 8'hFB, 1'h0);
    chk(readout_lock, 1'h1);
    por();
    chk({readout_lock, boot_from_loader}, 2'h1);
    rs(4'h1, 1'h1, 1'h1);
    pw(2'h0, 8'hFF, 1'h1);
    por();
    chk(loader_present, 1'h0);
    $display("done programmer");
    boot(8'hFD, 8'hDC, 8'hFE);
    chk(wdog_control_reg, 8'h20);
    rs(4'h2, 1'h0, 1'h1);
    rs(4'h4, 1'h0, 1'h1);
    rs(4'h8, 1'h1, 1'h0);
    rs(4'h1, 1'h1, 1'h0);
    boot(8'hE1, 8'hDC, 8'hFF);
    rs(4'h8, 1'h0, 1'h1);
    rs(4'h2, 1'h1, 1'h0);
    rs(4'h4, 1'h1, 1'h0);
    rs(4'h1, 1'h1, 1'h1);
    $display("done resets");
    boot(8'hFD, 8'hDC, 8'h20);
    chk(wdog_control_reg, 8'h7D);
    wd(8'h00, 8'h3D);
    boot(8'hFD, 8'hDC, 8'hA6);
    chk(wdog_control_reg, 8'h20);
    wd(8'h5A, 8'h5A);
    chk(wdog_reset_enable, 1'h0);
    $display("done watchdog");
    close_out();
  end
endmodule

// *** test/hofl_nv_model.sv ***
// option store model answering the loader's fetches
`timescale 1ns/10ps
module hofl_nv_model (
  // clock
  input wire logic mclk,
  // loader side
  input wire logic nv_rd,
  input wire logic [1:0] nv_addr,
  input wire logic nv_wr,
  input wire logic nv_erase,
  input wire logic [7:0] nv_wdata,
  output logic [7:0] nv_rdata
);
  logic [7:0] mem [0:3];
  // data is valid one cycle only, then toggles so a late sample cannot match
  initial nv_rdata = 8'h00;
  always @(posedge mclk)
  begin
    if (nv_rd)
      nv_rdata <= mem[nv_addr];
    else
      nv_rdata <= ~nv_rdata;
  end
  // programmer writes land here; erase blanks every byte
  always @(posedge mclk)
  begin
    if (nv_erase)
      mem <= '{default: 8'hFF};
    else if (nv_wr)
      mem[nv_addr] <= nv_wdata;
  end
endmodule
